// File: src/fbsram_pkg.sv
package fbsram_pkg;

  // ----------------------------------------------------------------
  // Organisation and timing constants
  // ----------------------------------------------------------------
  localparam int LANE_DATA_W = 8;
  localparam int BURST_LEN = 4;
  localparam int BURST_W = 2;
  localparam int SLEEP_ENTER_CYCLES = 2;
  localparam int SLEEP_EXIT_CYCLES = 2;
  localparam int SLEEP_CNT_W = 2;
  localparam int WIDE_LANES = 4;
  localparam int WIDE_ADDR_W = 19;
  localparam int NARROW_LANES = 2;
  localparam int NARROW_ADDR_W = 20;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FBSRAM_DESEL = 2'b00,
    FBSRAM_READ = 2'b01,
    FBSRAM_WRITE = 2'b10
  } fbsram_access_t;

  typedef enum logic [1:0] {
    FBSRAM_AWAKE = 2'b00,
    FBSRAM_ENTER = 2'b01,
    FBSRAM_ASLEEP = 2'b10,
    FBSRAM_WAKE = 2'b11
  } fbsram_sleep_t;

endpackage

// File: src/fbsram_burst_step.sv
`timescale 1ns/100ps
// --------------------------------------------------------------------
// Burst address sequencer for the two lowest address bits
// --------------------------------------------------------------------
module fbsram_burst_step
  import fbsram_pkg::*;
(
  // Burst position
  input wire logic [BURST_W-1:0] start_low,
  input wire logic [BURST_W-1:0] beat,
  input wire logic interleaved,
  // Resulting low address bits
  output logic [BURST_W-1:0] addr_low
);

  // Linear adds and wraps; interleaved flips bits of the start.
  always_comb begin
    if (interleaved) begin
      addr_low = start_low ^ beat;
    end else begin
      addr_low = start_low + beat;
    end
  end

endmodule // fbsram_burst_step

// File: src/fbsram_array.sv
`timescale 1ns/100ps
// --------------------------------------------------------------------
// Storage array with per-lane writes and a registered read port
// --------------------------------------------------------------------
module fbsram_array
  import fbsram_pkg::*;
#(
  parameter int ADDR_W = WIDE_ADDR_W,
  parameter int LANES = WIDE_LANES
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [LANES-1:0] wr_lane,
  input wire logic [LANES*LANE_DATA_W-1:0] wr_data,
  input wire logic [LANES-1:0] wr_parity,
  // Read port
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [LANES*LANE_DATA_W-1:0] rd_data,
  output logic [LANES-1:0] rd_parity
);

  localparam int LW = LANE_DATA_W + 1;

  // Each lane keeps data and parity together in an array of its own, so
  // every lane process owns all that it writes; no reset, as in a RAM.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [LW-1:0] mem [2**ADDR_W];
    logic [LW-1:0] wr_word;
    logic [LW-1:0] rd_word;
    logic bypass;
    assign wr_word = {wr_parity[i], wr_data[i*LANE_DATA_W +: LANE_DATA_W]};
    // A read of the word written at the same edge sees the new byte.
    assign bypass = wr_en && wr_lane[i] && (wr_addr == rd_addr);
    always_ff @(posedge clk) begin
      if (wr_en && wr_lane[i]) begin
        mem[wr_addr] <= wr_word;
      end
      if (rd_en) begin
        rd_word <= bypass ? wr_word : mem[rd_addr];
      end
    end
    // The lane word goes out on its own slice of the shared read pins.
    assign rd_data[i*LANE_DATA_W +: LANE_DATA_W] = rd_word[LANE_DATA_W-1:0];
    assign rd_parity[i] = rd_word[LANE_DATA_W];
  end

endmodule // fbsram_array

// File: src/fbsram_core.sv
`timescale 1ns/100ps
// --------------------------------------------------------------------
// --------------------------------------------------------------------
module fbsram_core
  import fbsram_pkg::*;
#(
  parameter bit WIDE = 1'b1,
  parameter int LANES = WIDE ? WIDE_LANES : NARROW_LANES,
  parameter int ADDR_W = WIDE ? WIDE_ADDR_W : NARROW_ADDR_W
) (
  // Clock and power-up reset
  input wire logic clk,
  input wire logic rst_n,
  // Address and cycle control
  input wire logic [ADDR_W-1:0] address,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic burst_advance_load_n,
  input wire logic write_enable_n,
  input wire logic [LANES-1:0] byte_write_select_n,
  input wire logic clock_qualify_n,
  input wire logic burst_order_select,
  // Asynchronous controls
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // Data and parity pins
  input wire logic [LANES*LANE_DATA_W-1:0] data_in,
  input wire logic [LANES-1:0] parity_lane_in,
  output logic [LANES*LANE_DATA_W-1:0] data_out,
  output logic [LANES-1:0] parity_lane_out,
  output logic data_oe,
  // Power state
  output logic sleep_active
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (!((LANES == WIDE_LANES && ADDR_W == WIDE_ADDR_W) ||
        (LANES == NARROW_LANES && ADDR_W == NARROW_ADDR_W))) begin : g_chk
    $error("Organisation must be 512K x 36 or 1M x 18.");
  end

  // The beat counter wraps on its own width, which is the burst length.
  if (2 ** BURST_W != BURST_LEN) begin : g_chk_burst
    $error("Burst length must equal two to the beat width.");
  end

  // The sleep counters start at one and stop at their count less one,
  // so a count below two, or one beyond the counter, would end at the wrong count.
  if (SLEEP_ENTER_CYCLES < 2 || SLEEP_EXIT_CYCLES < 2 ||
      SLEEP_ENTER_CYCLES > 2 ** SLEEP_CNT_W ||
      SLEEP_EXIT_CYCLES > 2 ** SLEEP_CNT_W) begin : g_chk_sleep
    $error("Sleep counts must fit the sleep counter.");
  end

  // The burst steps only the low address bits; the rest is the base.
  if (ADDR_W <= BURST_W) begin : g_chk_addr
    $error("Address too narrow for the burst counter.");
  end

  // ------------------------------------------------------------------
  // Sleep sequencing
  // ------------------------------------------------------------------
  fbsram_sleep_t sleep_state;
  fbsram_sleep_t next_sleep_state;
  logic [SLEEP_CNT_W-1:0] sleep_cnt;
  logic [SLEEP_CNT_W-1:0] next_sleep_cnt;
  logic awake;

  // Entry and exit each take a fixed count of clocks; a request that
  // drops during entry walks back out through the wake count.
  always_comb begin
    next_sleep_state = sleep_state;
    next_sleep_cnt = sleep_cnt;
    case (sleep_state)
      FBSRAM_AWAKE: begin
        // A request starts the entry count at once.
        if (sleep_request) begin
          next_sleep_state = FBSRAM_ENTER;
          next_sleep_cnt = SLEEP_CNT_W'(1);
        end
      end
      FBSRAM_ENTER: begin
        // Dropping the request here backs out through the wake count.
        if (!sleep_request) begin
          next_sleep_state = FBSRAM_WAKE;
          next_sleep_cnt = SLEEP_CNT_W'(1);
        end else if (sleep_cnt ==
                     SLEEP_CNT_W'(SLEEP_ENTER_CYCLES - 1)) begin
          next_sleep_state = FBSRAM_ASLEEP;
        end else begin
          next_sleep_cnt = sleep_cnt + SLEEP_CNT_W'(1);
        end
      end
      FBSRAM_ASLEEP: begin
        // Contents stay put; only the falling request matters here.
        if (!sleep_request) begin
          next_sleep_state = FBSRAM_WAKE;
          next_sleep_cnt = SLEEP_CNT_W'(1);
        end
      end
      FBSRAM_WAKE: begin
        // Chip selects must stay off until this count has run out.
        if (sleep_request) begin
          next_sleep_state = FBSRAM_ENTER;
          next_sleep_cnt = SLEEP_CNT_W'(1);
        end else if (sleep_cnt ==
                     SLEEP_CNT_W'(SLEEP_EXIT_CYCLES - 1)) begin
          next_sleep_state = FBSRAM_AWAKE;
        end else begin
          next_sleep_cnt = sleep_cnt + SLEEP_CNT_W'(1);
        end
      end
      default: begin
        next_sleep_state = FBSRAM_AWAKE;
        next_sleep_cnt = '0;
      end
    endcase
  end

  // Sleep state registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_state <= FBSRAM_AWAKE;
      sleep_cnt <= '0;
    end else begin
      sleep_state <= next_sleep_state;
      sleep_cnt <= next_sleep_cnt;
    end
  end

  // The request itself blocks cycles at once, before the count ends.
  assign awake = (sleep_state == FBSRAM_AWAKE) && !sleep_request;
  assign sleep_active = (sleep_state == FBSRAM_ASLEEP);

  // ------------------------------------------------------------------
  // Cycle decode
  // ------------------------------------------------------------------
  // Registered burst state and the write that waits for its data.
  fbsram_access_t access;
  fbsram_access_t next_access;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [BURST_W-1:0] beat;
  logic [BURST_W-1:0] next_beat;
  logic [LANES-1:0] wr_lane;
  logic [LANES-1:0] next_wr_lane;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic wr_pend;
  logic next_wr_pend;
  logic qualified;
  logic selected;
  logic step_rd;
  logic [BURST_W-1:0] low_bits;
  logic [ADDR_W-1:0] cycle_addr;

  // An edge counts only when awake and not stalled.
  assign qualified = awake && !clock_qualify_n;
  assign selected = !chip_select_first_n && chip_select_second &&
                    !chip_select_third_n;

  // Low address bits of this beat, from the next base and beat.
  fbsram_burst_step u_step (
    .start_low(next_base[BURST_W-1:0]),
    .beat(next_beat),
    .interleaved(burst_order_select),
    .addr_low(low_bits)
  );

  // Upper bits stay at the loaded base for the whole burst.
  assign cycle_addr = {next_base[ADDR_W-1:BURST_W], low_bits};

  // A load edge picks the access type once; advance edges keep it and
  // only step the beat, so the strobe alone steers a running burst.
  always_comb begin
    next_access = access;
    next_base = base;
    next_beat = beat;
    next_wr_lane = '0;
    next_wr_addr = wr_addr;
    next_wr_pend = 1'b0;
    step_rd = 1'b0;
    if (!qualified) begin
      next_wr_lane = wr_lane;
      next_wr_pend = wr_pend;
      if (sleep_request) begin
        next_access = FBSRAM_DESEL;
        next_wr_pend = 1'b0;
      end
    end else begin
      if (!burst_advance_load_n) begin
        next_beat = '0;
        next_base = address;
        if (!selected) begin
          next_access = FBSRAM_DESEL;
        end else if (write_enable_n) begin
          next_access = FBSRAM_READ;
        end else begin
          next_access = FBSRAM_WRITE;
        end
      end else begin
        next_beat = beat + BURST_W'(1);
      end
      case (next_access)
        FBSRAM_READ: begin
          // Reads fetch on the taking edge, so data flows through.
          step_rd = 1'b1;
        end
        FBSRAM_WRITE: begin
          // Lanes are caught now; their data follows one edge later.
          next_wr_lane = ~byte_write_select_n;
          next_wr_addr = cycle_addr;
          next_wr_pend = 1'b1;
        end
        FBSRAM_DESEL: begin
          // A continued deselect holds the beat where it stood.
          next_beat = beat;
        end
        default: begin
          next_access = FBSRAM_DESEL;
        end
      endcase
    end
  end

  // Cycle state registers; reset clears the burst state and the pending write alike.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      access <= FBSRAM_DESEL;
      base <= '0;
      beat <= '0;
      wr_lane <= '0;
      wr_addr <= '0;
      wr_pend <= 1'b0;
    end else begin
      access <= next_access;
      base <= next_base;
      beat <= next_beat;
      wr_lane <= next_wr_lane;
      wr_addr <= next_wr_addr;
      wr_pend <= next_wr_pend;
    end
  end

  // ------------------------------------------------------------------
  // Storage and data pins
  // ------------------------------------------------------------------
  logic wr_now;

  // Data of an earlier write beat is taken on the next qualified edge.
  // A stall between address and data edges holds the pending write
  // unless sleep is requested, so the controller may insert wait states.
  assign wr_now = qualified && wr_pend && (wr_lane != '0);

  fbsram_array #(
    .ADDR_W(ADDR_W),
    .LANES(LANES)
  ) u_array (
    .clk(clk),
    .wr_en(wr_now),
    .wr_addr(wr_addr),
    .wr_lane(wr_lane),
    .wr_data(data_in),
    .wr_parity(parity_lane_in),
    .rd_en(step_rd),
    .rd_addr(cycle_addr),
    .rd_data(data_out),
    .rd_parity(parity_lane_out)
  );

  // Data and parity share one enable; there is no per-lane output
  // control, since a read always returns every lane of the word.
  // Drive only during a read beat with output enable low; this path is
  // unclocked so the enable acts at once, and reset or sleep wins.
  assign data_oe = rst_n && awake && (access == FBSRAM_READ) &&
                   !output_enable_n;

endmodule // fbsram_core

// File: testbench/fbsram_core_props.sv
`timescale 1ns/100ps
// ----
// Pin level checks of the cycle decoder
// ----
module fbsram_core_props
  import fbsram_pkg::*;
#(parameter int LANES = WIDE_LANES) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Cycle control
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic burst_advance_load_n,
  input wire logic write_enable_n,
  input wire logic clock_qualify_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // Outputs
  input wire logic [LANES*LANE_DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic sleep_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] quiet;
  logic rd_seen;
  logic ok;
  logic ld;
  logic cs;
  // Edges are trusted only well clear of sleep, since waking is slow.
  assign ok = (quiet == 2'h3);
  assign cs = !chip_select_first_n && chip_select_second
    && !chip_select_third_n;
  assign ld = ok && !clock_qualify_n && !burst_advance_load_n;
  // Settle counter after sleep, and a flag once read data exists.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 2'h0;
      rd_seen <= 1'b0;
    end else begin
      quiet <= (sleep_request || sleep_active) ? 2'h0
        : quiet + 2'(quiet != 2'h3);
      rd_seen <= rd_seen || (ld && cs && write_enable_n);
    end
  end
  oe_mask_a: assert property (output_enable_n |-> !data_oe)
    else $error("pins driven with output enable off");
  sleep_float_a: assert property (sleep_request |-> !data_oe)
    else $error("pins driven during sleep");
  reset_float_a: assert property ($rose(rst_n) |-> !data_oe)
    else $error("pins driven after power up");
  write_float_a: assert property (ld && cs && !write_enable_n
    |=> !data_oe) else $error("pins driven in write data phase");
  desel_float_a: assert property (ld && !cs |=> !data_oe)
    else $error("pins driven after deselect");
  read_drive_a: assert property (ld && cs && write_enable_n ##1
    (!output_enable_n && !sleep_request) |-> data_oe)
    else $error("read data not driven");
  stall_hold_a: assert property (ok && rd_seen && clock_qualify_n
    |=> $stable(data_out)) else $error("stalled edge moved data");
  sleep_enter_a: assert property ($rose(sleep_request) ##1
    sleep_request [*2] |-> sleep_active) else $error("sleep entry late");
  sleep_exit_a: assert property ($fell(sleep_request) ##1
    !sleep_request [*2] |-> !sleep_active) else $error("sleep exit late");
  cover property (ld && cs && write_enable_n);
  cover property (ld && cs && !write_enable_n);
  cover property (sleep_active);
endmodule // fbsram_core_props

bind fbsram_core fbsram_core_props #(.LANES(LANES))
  fbsram_core_props_inst (.*);

// File: testbench/fbsram_ctrl_model.sv
`timescale 1ns/100ps
// ----
// Controller side write data driver
// ----
module fbsram_ctrl_model
  import fbsram_pkg::*;
#(parameter int LANES = WIDE_LANES) (
  // Clock
  input wire logic clk,
  // Data for the coming data phase
  input wire logic wr_go,
  input wire logic [LANES*(LANE_DATA_W+1)-1:0] wdata,
  // Write data pins
  output logic [LANES*LANE_DATA_W-1:0] data_in,
  output logic [LANES-1:0] parity_lane_in
);
  initial {parity_lane_in, data_in} = '0;
  // Data leaves on the address edge for one cycle; otherwise the bus
  // toggles so that stale data can never pass for a good write.
  always @(posedge clk) begin
    if (wr_go) begin
      {parity_lane_in, data_in} <= wdata;
    end else begin
      {parity_lane_in, data_in} <= ~{parity_lane_in, data_in};
    end
  end
endmodule // fbsram_ctrl_model

// File: testbench/tb_top.sv
`timescale 1ns/100ps
// ----
// Bench for the burst memory cycle decoder
// ----
module tb_top
  import fbsram_pkg::*;
;
  logic clk, rst_n, chip_select_first_n, chip_select_second;
  logic chip_select_third_n, burst_advance_load_n, write_enable_n;
  logic clock_qualify_n, burst_order_select, output_enable_n;
  logic sleep_request, data_oe, sleep_active, wr_go, ty, sel;
  logic [3:0] byte_write_select_n, parity_lane_in, parity_lane_out;
  logic [31:0] data_in, data_out;
  logic [35:0] wdata, ex;
  logic [35:0] mem [logic [18:0]];
  logic [18:0] address, base;
  logic [1:0] bt;
  int mismatches, n_checks, seed;
  fbsram_core #(.WIDE(1'b1)) fbsram_core_inst (.clk(clk), .rst_n(rst_n),
    .address(address), .chip_select_first_n(chip_select_first_n),
    .chip_select_second(chip_select_second),
    .chip_select_third_n(chip_select_third_n),
    .burst_advance_load_n(burst_advance_load_n),
    .write_enable_n(write_enable_n),
    .byte_write_select_n(byte_write_select_n),
    .clock_qualify_n(clock_qualify_n),
    .burst_order_select(burst_order_select),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .data_in(data_in), .parity_lane_in(parity_lane_in),
    .data_out(data_out), .parity_lane_out(parity_lane_out),
    .data_oe(data_oe), .sleep_active(sleep_active));
  fbsram_ctrl_model #(.LANES(4)) fbsram_ctrl_model_inst (.clk(clk),
    .wr_go(wr_go), .wdata(wdata), .data_in(data_in),
    .parity_lane_in(parity_lane_in));
  // Free running clock, 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [35:0] e,
      input logic [35:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One beat: drive at the falling edge, judge after the rising edge.
  task automatic beat(input bit ld, input logic [2:0] c, input bit wr,
      input logic [3:0] bw);
    logic [18:0] a;
    if (ld) begin
      bt = 2'h0;
      ty = wr;
      sel = (c == 3'b010);
    end else begin
      bt = bt + 2'h1;
    end
    a = {base[18:2],
      burst_order_select ? base[1:0] ^ bt : base[1:0] + bt};
    {chip_select_first_n, chip_select_second, chip_select_third_n} = c;
    burst_advance_load_n = !ld;
    write_enable_n = !wr;
    byte_write_select_n = bw;
    address = base;
    wdata = 36'({$random(seed), $random(seed)});
    wr_go = sel && ty;
    for (int i = 0; i < 4; i++) begin
      if (sel && ty && !bw[i]) begin
        mem[a][8*i+:8] = wdata[8*i+:8];
        mem[a][32+i] = wdata[32+i];
      end
    end
    @(negedge clk);
    chk("data_oe", 36'(sel && !ty && !output_enable_n), 36'(data_oe));
    if (sel && !ty && !output_enable_n) begin
      ex = mem[a];
      chk("read word", ex, {parity_lane_out, data_out});
    end
  endtask
  // A stalled edge, with output enable toggled inside it.
  task automatic stall;
    clock_qualify_n = 1'b1;
    #5 output_enable_n = 1'b1;
    #1 chk("oe off", 36'h0, 36'(data_oe));
    output_enable_n = 1'b0;
    #1 chk("oe on", 36'h1, 36'(data_oe));
    @(negedge clk);
    clock_qualify_n = 1'b0;
    chk("stalled word", ex, {parity_lane_out, data_out});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    seed = 88;
    {mismatches, n_checks, rst_n, wr_go, wdata, ex, bt} = '0;
    {address, base, ty, sel, clock_qualify_n, sleep_request} = '0;
    {burst_order_select, output_enable_n, burst_advance_load_n} = '0;
    {write_enable_n, byte_write_select_n} = '1;
    {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h5;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("oe in reset", 36'h0, 36'(data_oe));
    rst_n = 1'b1;
    @(negedge clk);
    chk("oe after reset", 36'h0, 36'(data_oe));
    for (int o = 0; o < 2; o++) begin
      burst_order_select = o[0];
      base = 19'($random(seed));
      beat(1, 3'b010, 1, 4'h0);
      repeat (3) beat(0, 3'b101, 0, 4'h0);
      beat(1, 3'b010, 0, 4'h0);
      stall;
      repeat (3) beat(0, 3'b101, 1, 4'hf);
    end
    $display("test bursts done");
    for (int k = 0; k < 16; k++) begin
      beat(1, 3'b010, 1, 4'(k));
      beat(0, 3'b010, 0, 4'hf);
      beat(1, 3'b010, 0, 4'h0);
      beat(0, 3'b010, 0, 4'h0);
    end
    $display("test byte lanes done");
    output_enable_n = 1'b1;
    beat(1, 3'b010, 0, 4'h0);
    beat(0, 3'b101, 0, 4'h0);
    output_enable_n = 1'b0;
    beat(0, 3'b101, 0, 4'h0);
    $display("test dummy read done");
    for (int k = 0; k < 3; k++) begin
      beat(1, 3'b010 ^ (3'b100 >> k), 0, 4'h0);
      beat(0, 3'b010, 0, 4'h0);
    end
    $display("test deselect done");
    beat(1, 3'b101, 0, 4'h0);
    sleep_request = 1'b1;
    repeat (2) @(negedge clk);
    chk("asleep", 36'h1, 36'(sleep_active));
    {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h2;
    {write_enable_n, byte_write_select_n, wr_go} = 6'h01;
    repeat (3) begin
      @(negedge clk);
      chk("sleep oe", 36'h0, 36'(data_oe));
    end
    {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h5;
    {sleep_request, wr_go} = 2'h0;
    repeat (2) @(negedge clk);
    chk("awake", 36'h0, 36'(sleep_active));
    beat(1, 3'b010, 0, 4'h0);
    repeat (3) beat(0, 3'b010, 0, 4'h0);
    $display("test sleep done");
    final_report;
  end
endmodule // tb_top
